//--- eci_coupler_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus coupler side: fetches the input byte and object entries
module eci_coupler_model
(
  // clock
  input  wire logic        i_clk,
  // answers from the module
  input  wire logic [7:0]  i_img_rdata,
  input  wire logic        i_img_hit,
  input  wire logic [7:0]  i_obj_rdata,
  input  wire logic        i_obj_hit,
  // requests to the module
  output logic             o_img_rd,
  output logic [7:0]       o_img_addr,
  output logic             o_obj_rd,
  output logic [15:0]      o_object_index,
  output logic [7:0]       o_object_subentry
);
  // idle, no request at time zero
  initial
  begin
    o_img_rd = 1'b0;
    o_obj_rd = 1'b0;
    o_img_addr = 8'hFF;
    o_object_index = 16'hFFFF;
    o_object_subentry = 8'hFF;
  end
  //////////////////////////////////////////////////////////////////////////
  // one read: held through the taking edge, hit taken at that edge,
  // registered data taken at the next rising edge
  task automatic rd(input logic obj, input logic [15:0] idx,
    input logic [7:0] sub, output logic hit, output logic [7:0] data);
    @(posedge i_clk);
    o_img_rd <= ~obj;
    o_obj_rd <= obj;
    o_img_addr <= idx[7:0];
    o_object_index <= idx;
    o_object_subentry <= sub;
    @(posedge i_clk);
    hit = obj ? i_obj_hit : i_img_hit;
    o_img_rd <= 1'b0;
    o_obj_rd <= 1'b0;
    // released address lines flip so stale values never look valid
    o_img_addr <= ~idx[7:0];
    o_object_index <= ~idx;
    o_object_subentry <= ~sub;
    @(posedge i_clk);
    data = obj ? i_obj_rdata : i_img_rdata;
  endtask
endmodule // eci_coupler_model
`default_nettype wire

//--- eci_defs.svh
`ifndef ECI_DEFS_SVH
`define ECI_DEFS_SVH

// number of input channels
`define ECI_NUM_CH          8
// byte offset of the input state image
`define ECI_OFF_INPUT_STATE 8'h00
// object index and subentry range for per-bit access
`define ECI_OBJ_INDEX       16'h6000
`define ECI_SUB_FIRST       8'h01
`define ECI_SUB_LAST        8'h08
// filter delay, in microseconds, and clock period in nanoseconds
`define ECI_FILTER_US       3000
`define ECI_CLK_NS          100
// filter delay in clock cycles (3 ms at 10 MHz)
`define ECI_FILTER_CYC      ((`ECI_FILTER_US * 1000) / `ECI_CLK_NS)
// half period of the 2 Hz blink, in microseconds and cycles
`define ECI_BLINK_HALF_US   250000
`define ECI_BLINK_HALF_CYC  ((`ECI_BLINK_HALF_US * 1000) / `ECI_CLK_NS)
// counter widths
`define ECI_FCNT_W          15
`define ECI_BCNT_W          22
// arbitrary neutral identity value, not tied to any real part
`define ECI_MODULE_ID       32'h0000_0001

`endif

//--- eci_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "eci_defs.svh"

module eci_filter
  import eci_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // raw channel input
  input  wire logic i_raw,
  // filtered level
  output logic      o_level
);

  ////////////////////////////////////////////////////////////////////////////
  logic                   sync1_q;  // first stage, read only by sync2
  logic                   sync2_q;  // synchronised level
  logic                   level_q;  // filtered level
  logic [`ECI_FCNT_W-1:0] cnt_q;    // stable-time counter
  logic [`ECI_FCNT_W-1:0] cnt_d;

  localparam logic [`ECI_FCNT_W-1:0] FILT_LAST =
    `ECI_FCNT_W'(`ECI_FILTER_CYC - 1);

  wire differs = (sync2_q != level_q);
  wire expired = (cnt_q == FILT_LAST);

  // count while differing, restart once it matches again
  assign cnt_d = (differs && !expired) ? cnt_q + 1'b1 : '0;

  // two-flop synchroniser
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= i_raw;    // RQ16
      sync2_q <= sync1_q;
    end
  end

  // level follows after the delay of stable opposite level
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;                           // RQ16
      if (differs && expired)
        level_q <= sync2_q;                     // RQ5 RQ6
    end
  end

  assign o_level = level_q;

  // a change never shows before the full delay of stable input
  a_filter_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(level_q) |-> $past(cnt_q) == FILT_LAST) // RQ5
    else $error("filtered level changed before delay expired");

endmodule // eci_filter
`default_nettype wire

//--- eci_input_image.sv
`timescale 1ns/1ps
`default_nettype none
`include "eci_defs.svh"

// Behaviour
// RQ1: eight independent inputs, each with indicator
// RQ2: input byte at offset zero, bit n
// RQ3: object 6000h, subentries 01h-08h per bit
// RQ4: no output bytes; output writes ignored
// RQ5: rising edge shown after 3 ms stable
// RQ6: falling edge shown after 3 ms stable
// RQ7: channel lit when one and module ok; code lights it on one in every module state
// RQ8: channel dark when input reads zero
// RQ9: bus ok, no error: run on
// RQ10: error with bus: run and fault on
// RQ11: no bus with error: fault only
// RQ12: bus power fail: both indicators off
// RQ13: configuration error blinks fault at 2Hz
// RQ14: all eight inputs always enabled
// RQ15: no interrupts, diagnostics or config writes
// RQ16: synchronise inputs, restart filter on change
module eci_input_image
  import eci_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // field inputs
  input  wire logic [`ECI_NUM_CH-1:0] i_input_channel,
  // module status from the bus side
  input  wire logic                   i_bus_ok,
  input  wire logic                   i_bus_power_ok,
  input  wire logic                   i_module_error,
  input  wire logic                   i_config_error,
  // process image read by offset
  input  wire logic                   i_img_rd,
  input  wire logic [7:0]             i_img_addr,
  output logic [7:0]                  o_img_rdata,
  output logic                        o_img_hit,
  // process image write (no bytes mapped)
  input  wire logic                   i_img_wr,
  input  wire logic [7:0]             i_img_wdata,
  // object access
  input  wire logic                   i_obj_rd,
  input  wire logic [15:0]            i_object_index,
  input  wire logic [7:0]             i_object_subentry,
  output logic [7:0]                  o_obj_rdata,
  output logic                        o_obj_hit,
  // indicators
  output logic                        o_run_indicator,
  output logic                        o_fault_indicator,
  output logic [`ECI_NUM_CH-1:0]      o_channel_indicator,
  // fixed identity and tied-off interrupt
  output logic [31:0]                 o_module_id,
  output logic                        o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [`ECI_NUM_CH-1:0] input_state_image;  // filtered levels
  logic [7:0]             img_rdata_q;        // registered read data
  logic [7:0]             img_rdata_d;
  logic [7:0]             obj_rdata_q;
  logic [7:0]             obj_rdata_d;
  logic                   run_q;              // run indicator
  logic                   fault_q;            // fault indicator
  logic [`ECI_NUM_CH-1:0] chan_q;             // channel indicators
  logic [`ECI_BCNT_W-1:0] blink_cnt_q;        // 2 Hz half period
  logic                   blink_q;            // blink phase
  eci_state_type          state;              // decoded module state

  localparam logic [`ECI_BCNT_W-1:0] BLINK_LAST =
    `ECI_BCNT_W'(`ECI_BLINK_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // one filter per channel, none can be switched off
  genvar ch;
  generate
    for (ch = 0; ch < `ECI_NUM_CH; ch++)
    begin : g_chan
      eci_filter u_filter (                        // RQ1 RQ14
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_raw    (i_input_channel[ch]),
        .o_level  (input_state_image[ch])          // RQ2
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // process image decode; only offset zero is mapped
  wire img_sel  = (i_img_addr == `ECI_OFF_INPUT_STATE);
  assign o_img_hit = i_img_rd && img_sel;
  assign img_rdata_d = o_img_hit ? input_state_image : 8'h00;  // RQ2

  // writes reach nothing: the output image has no bytes here
  wire unused_wr = i_img_wr ^ (^i_img_wdata);      // RQ4

  // object decode; subentry 0 gives the whole byte
  wire       obj_idx  = (i_object_index == `ECI_OBJ_INDEX);
  wire       sub_bit  = (i_object_subentry >= `ECI_SUB_FIRST) &&
                        (i_object_subentry <= `ECI_SUB_LAST);
  wire [2:0] sub_pos  = 3'(i_object_subentry - `ECI_SUB_FIRST);
  wire       sub_whole = (i_object_subentry == 8'h00);
  assign o_obj_hit = i_obj_rd && obj_idx && (sub_bit || sub_whole);
  assign obj_rdata_d =
    !o_obj_hit ? 8'h00 :
    sub_whole  ? input_state_image :
                 {7'h00, input_state_image[sub_pos]};          // RQ3

  ////////////////////////////////////////////////////////////////////////////
  // read data registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      img_rdata_q <= 8'h00;
      obj_rdata_q <= 8'h00;
    end
    else
    begin
      img_rdata_q <= img_rdata_d;
      obj_rdata_q <= obj_rdata_d;
    end
  end

  assign o_img_rdata = img_rdata_q;
  assign o_obj_rdata = obj_rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // module state; configuration error overrides, then power
  assign state =
    i_config_error  ? ECI_ST_CFG_ERR  :           // RQ13
    !i_bus_power_ok ? ECI_ST_PWR_FAIL :           // RQ12
    !i_bus_ok       ? ECI_ST_ERR_NBUS :           // RQ11
    i_module_error  ? ECI_ST_ERR_BUS  :           // RQ10
                      ECI_ST_OK;                  // RQ9

  // 2 Hz blink timer, free running
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end
    else if (blink_cnt_q == BLINK_LAST)
    begin
      blink_cnt_q <= '0;
      blink_q     <= ~blink_q;                    // RQ13
    end
    else
      blink_cnt_q <= blink_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      run_q   <= 1'b0;
      fault_q <= 1'b0;
      chan_q  <= '0;
    end
    else
    begin
      // channels follow the filtered state: lit on one, dark on zero
      chan_q <= input_state_image;                // RQ7 RQ8
      case (state)
        ECI_ST_OK:
        begin
          run_q   <= 1'b1;                        // RQ9
          fault_q <= 1'b0;
        end
        ECI_ST_ERR_BUS:
        begin
          run_q   <= 1'b1;                        // RQ10
          fault_q <= 1'b1;
        end
        ECI_ST_ERR_NBUS:
        begin
          run_q   <= 1'b0;                        // RQ11
          fault_q <= 1'b1;
        end
        ECI_ST_PWR_FAIL:
        begin
          run_q   <= 1'b0;                        // RQ12
          fault_q <= 1'b0;
        end
        default:
        begin
          // run is don't-care; kept off to save a state
          run_q   <= 1'b0;
          fault_q <= blink_q;                     // RQ13
        end
      endcase
    end
  end

  assign o_run_indicator     = run_q;
  assign o_fault_indicator   = fault_q;
  assign o_channel_indicator = chan_q;
  assign o_module_id         = `ECI_MODULE_ID;
  // no interrupt source exists in this module
  assign o_irq               = 1'b0;              // RQ15

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_img_read_byte: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_img_rd && img_sel) |=> o_img_rdata == $past(input_state_image)) // RQ2
    else $error("image read did not return the input byte");

  a_obj_read_bit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_obj_hit && sub_bit) |=>
      o_obj_rdata == {7'h00, $past(input_state_image[sub_pos])}) // RQ3
    else $error("object subentry returned wrong bit");

  a_img_unmapped: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_img_rd && !img_sel) |=> o_img_rdata == 8'h00) // RQ4
    else $error("unmapped offset returned data");

  a_chan_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_channel_indicator == $past(input_state_image)) // RQ7
    else $error("channel indicator does not follow input");

  a_chan_dark: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !input_state_image[0] |=> !o_channel_indicator[0]) // RQ8
    else $error("channel indicator lit with input at zero");

  a_run_ok: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == ECI_ST_OK) |=> (o_run_indicator && !o_fault_indicator)) // RQ9
    else $error("ok state did not show run only");

  a_run_err: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == ECI_ST_ERR_BUS) |=> (o_run_indicator && o_fault_indicator)) // RQ10
    else $error("module error did not show run and fault");

  a_fault_nbus: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == ECI_ST_ERR_NBUS) |=> (!o_run_indicator && o_fault_indicator)) // RQ11
    else $error("no-bus error did not show fault only");

  a_power_dark: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == ECI_ST_PWR_FAIL) |=> (!o_run_indicator && !o_fault_indicator)) // RQ12
    else $error("power fail left an indicator on");

  a_blink_toggle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (blink_cnt_q == BLINK_LAST) |=> blink_q != $past(blink_q)) // RQ13
    else $error("blink phase did not toggle at half period");

  a_no_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !o_irq) // RQ15
    else $error("interrupt raised");

endmodule // eci_input_image
`default_nettype wire

//--- eci_pkg.sv
package eci_pkg;
  // module state as seen on the run and fault indicators
  typedef enum logic [2:0] {
    ECI_ST_OK       = 3'b000,
    ECI_ST_ERR_BUS  = 3'b001,
    ECI_ST_ERR_NBUS = 3'b010,
    ECI_ST_PWR_FAIL = 3'b011,
    ECI_ST_CFG_ERR  = 3'b100
  } eci_state_type;
endpackage

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock, reset and field side stimulus
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  chan = 8'h00;
  logic        bus_ok = 1'b1, pwr_ok = 1'b1, mod_err = 1'b0, cfg_err = 1'b0;
  logic        img_wr = 1'b0;
  logic [7:0]  img_wdata = 8'h00;
  // links between coupler model and module
  wire logic        img_rd, img_hit, obj_rd, obj_hit, run, fault, irq;
  wire logic [7:0]  img_addr, img_rdata, obj_sub, obj_rdata, chan_led;
  wire logic [15:0] obj_idx;
  // verdict counters
  int n_fail = 0;
  int check_count = 0;
  logic       hit;
  logic [7:0] data;

  always #50 i_clk = ~i_clk;

  eci_input_image dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_input_channel(chan), .i_bus_ok(bus_ok), .i_bus_power_ok(pwr_ok),
    .i_module_error(mod_err), .i_config_error(cfg_err), .i_img_rd(img_rd),
    .i_img_addr(img_addr), .o_img_rdata(img_rdata), .o_img_hit(img_hit),
    .i_img_wr(img_wr), .i_img_wdata(img_wdata), .i_obj_rd(obj_rd),
    .i_object_index(obj_idx), .i_object_subentry(obj_sub),
    .o_obj_rdata(obj_rdata), .o_obj_hit(obj_hit), .o_run_indicator(run),
    .o_fault_indicator(fault), .o_channel_indicator(chan_led),
    .o_module_id(), .o_irq(irq));

  eci_coupler_model cpl_u (.i_clk(i_clk), .i_img_rdata(img_rdata),
    .i_img_hit(img_hit), .i_obj_rdata(obj_rdata), .i_obj_hit(obj_hit),
    .o_img_rd(img_rd), .o_img_addr(img_addr), .o_obj_rd(obj_rd),
    .o_object_index(obj_idx), .o_object_subentry(obj_sub));

  //////////////////////////////////////////////////////////////////////////
  // compare and count; four-state so unknowns never match
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task finish_test;
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // read and judge one place; object reads when obj is set
  task rd_chk(input string what, input logic obj, input logic [15:0] idx,
    input logic [7:0] sub, input logic ehit, input logic [7:0] edata);
    cpl_u.rd(obj, idx, sub, hit, data);
    check({what, " hit"}, {31'h0, hit}, {31'h0, ehit});
    check(what, {24'h0, data}, {24'h0, edata});
  endtask

  //////////////////////////////////////////////////////////////////////////
  // state while reset is held, then the first read after release
  task t_reset;
    check("idle leds", {22'h0, run, fault, chan_led}, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wait_cyc(1);
    i_arst_n <= 1'b1;
    wait_cyc(1);
    rd_chk("image", 1'b0, 16'h0000, 8'h00, 1'b1, 8'h00);
  endtask

  // every row of the run and fault table
  task t_status;
    logic [3:0] stim [5];
    logic [1:0] exp [5];
    stim = '{4'hC, 4'hE, 4'h6, 4'h8, 4'hD};
    exp = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b00};
    for (int i = 0; i < 5; i++)
    begin
      {bus_ok, pwr_ok, mod_err, cfg_err} <= stim[i];
      wait_cyc(3);
      // blink phase starts dark and first flips after a quarter of a second
      check("run fault", {30'h0, run, fault}, {30'h0, exp[i]});
    end
    {bus_ok, pwr_ok, mod_err, cfg_err} <= 4'hC;
    wait_cyc(3);
  endtask

  // filter on both edges, with a glitch that must restart channel 1
  task t_filter;
    chan <= 8'hA7;
    wait_cyc(20000);
    chan <= 8'hA5;
    wait_cyc(2);
    chan <= 8'hA7;
    wait_cyc(9988);
    rd_chk("early rise", 1'b0, 16'h0000, 8'h00, 1'b1, 8'h00);
    wait_cyc(20);
    rd_chk("rise", 1'b0, 16'h0000, 8'h00, 1'b1, 8'hA5);
    check("leds on", {24'h0, chan_led}, 32'hA5);
    wait_cyc(20010);
    rd_chk("late rise", 1'b0, 16'h0000, 8'h00, 1'b1, 8'hA7);
    for (int s = 1; s <= 8; s++)
      rd_chk("obj bit", 1'b1, 16'h6000, s[7:0], 1'b1, {7'h0, chan[s-1]});
    rd_chk("obj sub9", 1'b1, 16'h6000, 8'h09, 1'b0, 8'h00);
    rd_chk("obj index", 1'b1, 16'h6001, 8'h01, 1'b0, 8'h00);
    rd_chk("image +1", 1'b0, 16'h0001, 8'h00, 1'b0, 8'h00);
    img_wr <= 1'b1;
    img_wdata <= 8'h00;
    wait_cyc(1);
    img_wr <= 1'b0;
    rd_chk("after write", 1'b0, 16'h0000, 8'h00, 1'b1, 8'hA7);
    chan <= 8'h06;
    wait_cyc(29990);
    rd_chk("early fall", 1'b0, 16'h0000, 8'h00, 1'b1, 8'hA7);
    wait_cyc(20);
    rd_chk("fall", 1'b0, 16'h0000, 8'h00, 1'b1, 8'h06);
    check("leds off", {24'h0, chan_led}, 32'h06);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    wait_cyc(105000);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial
  begin
    wait_cyc(1);
    t_reset();
    t_status();
    t_filter();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
